// File: scol_pkg.sv
// Purpose : Shared constants for the sixteen channel output latch card.
// Assumes : Four register numbers on the backplane, eight data bits each.
// Notes   : All offsets, field positions and eight bit reset values live here.
package scol_pkg;

  // ------------------------------------------------------------------
  // Register numbers
  // ------------------------------------------------------------------
  localparam logic [1:0] REG_IDENT = 2'h0;
  localparam logic [1:0] REG_CONST = 2'h1;
  localparam logic [1:0] REG_UPPER = 2'h2;
  localparam logic [1:0] REG_LOWER = 2'h3;

  // ------------------------------------------------------------------
  // Field layout of the identification byte
  // ------------------------------------------------------------------
  localparam int         ID_TYPE_LSB  = 0;
  localparam int         ID_TYPE_W    = 3;
  localparam int         ID_COMP_LSB  = 3;
  localparam int         ID_COMP_W    = 5;
  localparam logic [2:0] TYPE_ABSENT  = 3'h7;

  // ------------------------------------------------------------------
  // Values
  // ------------------------------------------------------------------
  // Hardwired readback, decimal 16 as an eight bit two's complement (the low eight bits of -240)
  localparam logic [7:0] CONST_READBACK = 8'h10;
  localparam logic [7:0] LATCH_RESET    = 8'h00;
  localparam logic [7:0] RDATA_RESET    = 8'h00;
  localparam logic [7:0] ID_RESET       = 8'hff;
  // Arbitrary component code, not taken from any real card
  localparam logic [4:0] COMP_CODE_DEF  = 5'h0c;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic reg_hit(input logic       strobe,
                                   input logic [1:0] addr,
                                   input logic [1:0] idx);
    reg_hit = strobe && (addr == idx);
  endfunction

endpackage

// File: scol_latch.sv
// Purpose : One eight channel command latch.
// Assumes : Clear and load are single cycle strobes from the top.
// Notes   : Clear beats load so a reset is never undone by a late write.
`timescale 1ns/1ps
module scol_latch
  import scol_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_clear,
  input  wire logic       i_load,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_q
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_q <= LATCH_RESET;
    end else if (i_clear) begin
      o_q <= LATCH_RESET;
    end else if (i_load) begin
      o_q <= i_data;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_LATCH_CLEAR: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_clear |=> (o_q == LATCH_RESET) [*1] ##0 $past(i_clear))
    else $error("latch not cleared after clear strobe");

  AST_LATCH_HOLD: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (!i_clear && !i_load) [*2] |-> $stable(o_q))
    else $error("latch changed without load or clear");

endmodule

// File: scol_ident.sv
// Purpose : Builds the identification byte from the terminal sense lines.
// Assumes : Sense lines are synchronous and settle before a read.
// Notes   : Registered, so the byte trails the sense lines by one cycle.
`timescale 1ns/1ps
module scol_ident
  import scol_pkg::*;
#(
  parameter logic [4:0] COMP_CODE = COMP_CODE_DEF
)
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_term_present,
  input  wire logic [2:0] i_term_type,
  output logic      [7:0] o_id
);

  logic [7:0] next_id;

  // ------------------------------------------------------------------
  // Field assembly
  // ------------------------------------------------------------------
  always_comb begin
    next_id = 8'h00;
    next_id[ID_COMP_LSB +: ID_COMP_W] = COMP_CODE;
    if (i_term_present) begin
      next_id[ID_TYPE_LSB +: ID_TYPE_W] = i_term_type;
    end else begin
      next_id[ID_TYPE_LSB +: ID_TYPE_W] = TYPE_ABSENT;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_id <= ID_RESET;
    end else begin
      o_id <= next_id;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_ID_ABSENT: assert property (
    @(posedge i_clk) disable iff (i_reset)
    !i_term_present |=> (o_id[ID_TYPE_LSB +: ID_TYPE_W] == TYPE_ABSENT))
    else $error("absent terminal module not flagged");

  AST_ID_FIELDS: assert property (
    @(posedge i_clk) disable iff (i_reset)
    i_term_present |=> (o_id == {COMP_CODE, $past(i_term_type)}))
    else $error("identification fields wrong");

endmodule

// File: scol_top.sv
// Purpose : Control logic of a sixteen channel open drain output card.
// Assumes : Backplane strobes are one cycle wide and synchronous to i_clk.
// Notes   : Outputs show the programmed state, not the switch state.
//
// Summary of operation
// - Register 0 read puts the identification byte on data bits 7:0.
// - ID byte: five bit component code over three bit terminal type.
// - With no terminal module fitted the three type bits read all ones.
// - Register 1 always reads the fixed value decimal 16, the low eight bits of -240.
// - Register 2 reads back the latched state of channels 8 to 15.
// - Register 3 reads back the latched state of channels 0 to 7.
// - Any write to register 0 resets the card and opens every channel.
// - Writing register 0 acts exactly like the backplane reset.
// - Writing register 2 loads channels 8 to 15; a one turns on.
// - Writing register 3 loads channels 0 to 7; a one turns on.
// - Bits map in ascending order, lowest bit to lowest channel.
// - A set latched bit drives its channel on; a clear bit releases it.
`timescale 1ns/1ps
module scol_top
  import scol_pkg::*;
#(
  // Arbitrary component code, chosen only to be neutral
  parameter logic [4:0] COMP_CODE = COMP_CODE_DEF
)
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_bp_reset,
  input  wire logic [1:0]  i_bus_addr,
  input  wire logic        i_bus_rd,
  input  wire logic        i_bus_wr,
  input  wire logic [7:0]  i_bus_wdata,
  input  wire logic        i_term_present,
  input  wire logic [2:0]  i_term_type,
  output logic      [7:0]  o_bus_rdata,
  output logic             o_bus_rvalid,
  output logic             o_card_reset,
  output logic      [15:0] o_channel_on
);

  // ------------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------------
  logic       wr_ident;
  logic       wr_upper;
  logic       wr_lower;
  logic       rd_any;
  logic       card_reset;
  logic [7:0] upper_q;
  logic [7:0] lower_q;
  logic [7:0] id_value;
  logic [7:0] next_rdata;

  // The data value of a reset write is ignored on purpose
  assign wr_ident   = reg_hit(i_bus_wr, i_bus_addr, REG_IDENT);
  assign wr_upper   = reg_hit(i_bus_wr, i_bus_addr, REG_UPPER);
  assign wr_lower   = reg_hit(i_bus_wr, i_bus_addr, REG_LOWER);
  assign rd_any     = i_bus_rd;

  // One reset path for both sources keeps the two identical
  assign card_reset = i_bp_reset || wr_ident;

  // ------------------------------------------------------------------
  // Identification
  // ------------------------------------------------------------------
  scol_ident #(
    .COMP_CODE      (COMP_CODE)
  ) u_ident (
    .i_clk          (i_clk),
    .i_reset        (i_reset),
    .i_term_present (i_term_present),
    .i_term_type    (i_term_type),
    .o_id           (id_value)
  );

  // ------------------------------------------------------------------
  // Channel latches
  // ------------------------------------------------------------------
  scol_latch u_upper (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_clear (card_reset),
    .i_load  (wr_upper),
    .i_data  (i_bus_wdata),
    .o_q     (upper_q)
  );

  scol_latch u_lower (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_clear (card_reset),
    .i_load  (wr_lower),
    .i_data  (i_bus_wdata),
    .o_q     (lower_q)
  );

  // Drivers follow the latches directly; no sensing of the switches
  assign o_channel_on = {upper_q, lower_q};

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always_comb begin
    next_rdata = RDATA_RESET;
    case (i_bus_addr)
      REG_IDENT: begin
        next_rdata = id_value;
      end
      REG_CONST: begin
        next_rdata = CONST_READBACK;
      end
      REG_UPPER: begin
        next_rdata = upper_q;
      end
      REG_LOWER: begin
        next_rdata = lower_q;
      end
      default: begin
        next_rdata = RDATA_RESET;
      end
    endcase
  end

  // Read data hold between reads so a slow controller can sample late
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_bus_rdata <= RDATA_RESET;
    end else if (rd_any) begin
      o_bus_rdata <= next_rdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_bus_rvalid <= 1'b0;
    end else begin
      o_bus_rvalid <= rd_any;
    end
  end

  // ------------------------------------------------------------------
  // Reset indication
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_card_reset <= 1'b0;
    end else begin
      o_card_reset <= card_reset;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_rd(logic [1:0] idx);
    i_bus_rd && (i_bus_addr == idx);
  endsequence

  sequence s_quiet_rd(logic [1:0] idx);
    i_bus_rd && (i_bus_addr == idx) && !i_bus_wr && !i_bp_reset;
  endsequence

  sequence s_reset_src;
    i_bp_reset || (i_bus_wr && (i_bus_addr == REG_IDENT));
  endsequence

  sequence s_clear_then_read;
    s_reset_src ##1 s_quiet_rd(REG_UPPER);
  endsequence

  AST_ID_READ: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_rd(REG_IDENT) |=> o_bus_rvalid && (o_bus_rdata == $past(id_value)))
    else $error("identification read returned wrong byte");

  AST_ID_ABSENT_READ: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (!i_term_present ##1 (s_rd(REG_IDENT) && !i_term_present))
    |=> (o_bus_rdata[ID_TYPE_LSB +: ID_TYPE_W] == TYPE_ABSENT))
    else $error("missing terminal module not visible on read");

  AST_CONST_READ: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_rd(REG_CONST) |=> (o_bus_rdata == CONST_READBACK))
    else $error("fixed register read wrong value");

  AST_UPPER_READ: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_quiet_rd(REG_UPPER) |=> (o_bus_rdata == o_channel_on[15:8]))
    else $error("upper readback differs from upper latch");

  AST_LOWER_READ: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_quiet_rd(REG_LOWER) |=> (o_bus_rdata == o_channel_on[7:0]))
    else $error("lower readback differs from lower latch");

  AST_WR0_OPENS_ALL: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (i_bus_wr && (i_bus_addr == REG_IDENT)) |=>
      (o_channel_on == 16'h0000) && o_card_reset)
    else $error("write to register 0 left channels on");

  AST_RESET_EQUIV: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_reset_src |=> (o_channel_on == 16'h0000) && o_card_reset
      ##1 (o_card_reset == $past(card_reset)))
    else $error("reset sources do not act alike");

  AST_UPPER_LOAD: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (wr_upper && !i_bp_reset) |=>
      (o_channel_on[15:8] == $past(i_bus_wdata)) && $stable(lower_q))
    else $error("upper command word not loaded");

  AST_LOWER_LOAD: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (wr_lower && !i_bp_reset) |=>
      (o_channel_on[7:0] == $past(i_bus_wdata)) && $stable(upper_q))
    else $error("lower command word not loaded");

  AST_BIT_ORDER: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (wr_lower && !i_bp_reset && (i_bus_wdata == 8'h01)) |=>
      (o_channel_on == {upper_q, 8'h01}) && o_channel_on[0])
    else $error("lowest command bit did not reach lowest channel");

  AST_DRIVE_HOLD: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (!i_bus_wr && !i_bp_reset) |=> $stable(o_channel_on))
    else $error("channel drive changed with no command");

  AST_CLEAR_READS_ZERO: assert property (
    @(posedge i_clk) disable iff (i_reset)
    s_clear_then_read |=> (o_bus_rdata == LATCH_RESET) && o_bus_rvalid)
    else $error("latch not zero when read after reset");

endmodule

// File: scol_ctl_model.sv
// Purpose : Backplane local controller model issuing register cycles.
// Assumes : One strobe per cycle; a read answers one edge after its strobe.
// Notes   : Idle address and data lines show the inverse of the last value,
//           so a design that samples them outside a strobe is caught.
`timescale 1ns/1ps
module scol_ctl_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  output logic      [1:0] o_addr,
  output logic            o_rd,
  output logic            o_wr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_addr  = 2'h0;
    o_rd    = 1'b0;
    o_wr    = 1'b0;
    o_wdata = 8'h00;
  end

  // ------------------------------------------------------------------
  // Register cycles
  // ------------------------------------------------------------------
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask

  // Byte is returned raw; the caller reads it as two's complement
  task automatic reg_read(input  logic [1:0] a,
                          output logic [7:0] d,
                          output logic       v);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
    v = i_rvalid;
  endtask
endmodule

// File: tb_top.sv
// Purpose : Self-checking bench for the sixteen channel output latch.
// Assumes : The controller model issues all register cycles.
// Notes   : Expectations are built from literals, never from the design.
`timescale 1ns/1ps
module tb_top;
  import scol_pkg::*;
  // Arbitrary component code
  localparam logic [4:0] TB_COMP = 5'h15;

  logic        clk = 1'b0;
  logic        rst, bp_rst, rd, wr, rvalid, card_rst, present;
  logic [1:0]  addr;
  logic [2:0]  ttype;
  logic [7:0]  wdata, rdata;
  logic [15:0] chan;
  int          bad_count = 0;
  int          cmp_count = 0;

  always #2 clk = ~clk;

  scol_top #(.COMP_CODE(TB_COMP)) uut (
    .i_clk(clk), .i_reset(rst), .i_bp_reset(bp_rst), .i_bus_addr(addr),
    .i_bus_rd(rd), .i_bus_wr(wr), .i_bus_wdata(wdata),
    .i_term_present(present), .i_term_type(ttype), .o_bus_rdata(rdata),
    .o_bus_rvalid(rvalid), .o_card_reset(card_rst), .o_channel_on(chan));

  scol_ctl_model ctl (
    .i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr),
    .o_rd(rd), .o_wr(wr), .o_wdata(wdata));

  // ------------------------------------------------------------------
  // Compare tasks
  // ------------------------------------------------------------------
  task automatic check1(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %b want %b", $time, m, got, exp);
    end
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                        input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp,
                         input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic read_chk(input logic [1:0] a, input logic [7:0] exp,
                          input string m);
    logic [7:0] d;
    logic       v;
    ctl.reg_read(a, d, v);
    check1(v, 1'b1, m);
    check8(d, exp, m);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_after_reset();
    check16(chan, 16'h0000, "channels after reset");
    read_chk(REG_UPPER, 8'h00, "upper after reset");
    read_chk(REG_LOWER, 8'h00, "lower after reset");
    read_chk(REG_CONST, 8'h10, "fixed value");
    $display("test after_reset done");
  endtask

  // Probe card kind and terminal presence for every sense code
  task automatic t_ident();
    for (int p = 0; p < 2; p++) begin
      for (int t = 0; t < 8; t++) begin
        @(posedge clk);
        present <= p[0];
        ttype   <= t[2:0];
        @(posedge clk);
        read_chk(REG_IDENT, {TB_COMP, p[0] ? t[2:0] : 3'h7},
                 "ident");
      end
    end
    $display("test ident done");
  endtask

  task automatic t_write_map();
    for (int i = 0; i < 8; i++) begin
      ctl.reg_write(REG_LOWER, 8'h01 << i);
      ctl.reg_write(REG_UPPER, 8'h80 >> i);
      #1;
      check8(chan[15:8], 8'h80 >> i, "walking upper");
      check8(chan[7:0], 8'h01 << i, "walking lower");
      read_chk(REG_UPPER, 8'h80 >> i, "upper readback");
      read_chk(REG_LOWER, 8'h01 << i, "lower readback");
    end
    ctl.reg_write(REG_CONST, 8'hff);
    #1;
    check16(chan, 16'h0180, "write to fixed register");
    read_chk(REG_CONST, 8'h10, "fixed after write");
    $display("test write_map done");
  endtask

  task automatic t_reg0_reset();
    for (int k = 0; k < 2; k++) begin
      ctl.reg_write(REG_UPPER, 8'h5a);
      ctl.reg_write(REG_LOWER, 8'ha5);
      ctl.reg_write(REG_IDENT, k[0] ? 8'hff : 8'h00);
      #1;
      check1(card_rst, 1'b1, "card reset pulse");
      check16(chan, 16'h0000, "all channels off");
      @(posedge clk);
      #1;
      check1(card_rst, 1'b0, "card reset pulse ends");
      read_chk(REG_UPPER, 8'h00, "upper after reg0");
      read_chk(REG_LOWER, 8'h00, "lower after reg0");
    end
    $display("test reg0_reset done");
  endtask

  // Backplane reset lands on the same edge as a load; the clear must win
  task automatic t_bp_reset();
    ctl.reg_write(REG_LOWER, 8'h3c);
    fork
      ctl.reg_write(REG_UPPER, 8'hc3);
      begin
        @(posedge clk);
        bp_rst <= 1'b1;
        @(posedge clk);
        bp_rst <= 1'b0;
      end
    join
    #1;
    check16(chan, 16'h0000, "bp reset beats load");
    check1(card_rst, 1'b1, "bp card reset");
    read_chk(REG_UPPER, 8'h00, "upper after bp");
    read_chk(REG_LOWER, 8'h00, "lower after bp");
    $display("test bp_reset done");
  endtask

  // ------------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------------
  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst     = 1'b1;
    bp_rst  = 1'b0;
    present = 1'b0;
    ttype   = 3'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_after_reset();
    t_ident();
    t_write_map();
    t_reg0_reset();
    t_bp_reset();
    stop_test();
  end

  // The whole run needs well under a thousand cycles
  initial begin
    #20000;
    bad_count++;
    $display("watchdog expired");
    stop_test();
  end
endmodule
